// file: ast_pkg.sv
/*
 holds register offsets, field positions, reset values, state codes and
 configuration types of the asynchronous serial unit.
 assumes a 32-bit AXI4-Lite slave with 8-bit registers in the low byte.
*/
package ast_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] AST_MODE_OFS = 8'h00;
    localparam logic [7:0] AST_RATE_OFS = 8'h04;
    localparam logic [7:0] AST_CTRL_OFS = 8'h08;
    localparam logic [7:0] AST_TXD_OFS = 8'h0C;
    localparam logic [7:0] AST_STAT_OFS = 8'h10;
    localparam logic [7:0] AST_RXD_OFS = 8'h14;
    // ----------------------------------------------------------------
    // reset values and status bit positions
    // ----------------------------------------------------------------
    localparam logic [7:0] AST_RATE_RST = 8'hFF;
    localparam logic [7:0] AST_STAT_RST = 8'h84;
    localparam int AST_ST_TXE = 7;
    localparam int AST_ST_RXF = 6;
    localparam int AST_ST_OVR = 5;
    localparam int AST_ST_FER = 4;
    localparam int AST_ST_PER = 3;
    localparam int AST_ST_TXD = 2;
    localparam int AST_ST_BRK = 0;
    // ----------------------------------------------------------------
    // oversampling points and bus response codes
    // ----------------------------------------------------------------
    localparam logic [3:0] AST_OVS_LAST = 4'hF;
    localparam logic [3:0] AST_OVS_MID = 4'h7;
    localparam logic [1:0] AST_RESP_OK = 2'h0;
    localparam logic [1:0] AST_RESP_ERR = 2'h2;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic len7;
        logic parEn;
        logic parOdd;
        logic stop2;
        logic msbFirst;
        logic [1:0] prescale;
    } ast_mode_t;
    typedef struct packed {
        logic txIe;
        logic rxIe;
        logic txEn;
        logic rxEn;
        logic spare;
        logic endIe;
        logic extClk;
        logic clkOut;
    } ast_ctrl_t;
    typedef enum logic [2:0] {
        AST_IDLE = 3'b000,
        AST_START = 3'b001,
        AST_DATA = 3'b010,
        AST_PAR = 3'b011,
        AST_STOP = 3'b100
    } ast_state_t;
endpackage : ast_pkg

// file: ast_async_serial_unit.sv
/*
 asynchronous serial transceiver with AXI4-Lite register access.
 assumes one clock mclk, a synchronous active-high reset, and rxd and sck
 pins that are asynchronous to mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ast_async_serial_unit
    import ast_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic rxdPin,
    output logic txdPin,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    output logic txEmptyIrq,
    output logic rxFullIrq,
    output logic rxErrIrq,
    output logic txEndIrq
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    ast_mode_t mode_reg, mode_next;
    ast_ctrl_t ctrl_reg, ctrl_next;
    logic [7:0] rate_reg, rate_next, txBuf_reg, txBuf_next;
    logic [7:0] rxBuf_reg, rxBuf_next, stat_reg, stat_next;
    logic [7:0] awa_reg, awa_next, wd_reg, wd_next;
    logic awHave_reg, awHave_next, wHave_reg, wHave_next, ws_reg, ws_next;
    logic bv_reg, bv_next, rv_reg, rv_next;
    logic [1:0] br_reg, br_next, rr_reg, rr_next;
    logic [31:0] rd_reg, rd_next;
    logic doWr, doRd, txWr, rxRd, stWr;
    always_comb begin
        doWr = awHave_reg && wHave_reg && !bv_reg;
        doRd = arvalid && !rv_reg;
        txWr = doWr && ws_reg && awa_reg == AST_TXD_OFS;
        stWr = doWr && ws_reg && awa_reg == AST_STAT_OFS;
        rxRd = doRd && araddr == AST_RXD_OFS;
        awHave_next = (awHave_reg && !doWr) || (awvalid && !awHave_reg);
        wHave_next = (wHave_reg && !doWr) || (wvalid && !wHave_reg);
        awa_next = (awvalid && !awHave_reg) ? awaddr : awa_reg;
        wd_next = (wvalid && !wHave_reg) ? wdata[7:0] : wd_reg;
        ws_next = (wvalid && !wHave_reg) ? wstrb[0] : ws_reg;
        bv_next = doWr || (bv_reg && !bready);
        br_next = br_reg;
        mode_next = mode_reg;
        ctrl_next = ctrl_reg;
        rate_next = rate_reg;
        if (doWr) begin
            br_next = AST_RESP_OK;
            if (ws_reg && awa_reg == AST_MODE_OFS) mode_next = wd_reg[6:0];
            if (ws_reg && awa_reg == AST_RATE_OFS) rate_next = wd_reg;
            if (ws_reg && awa_reg == AST_CTRL_OFS) begin
                ctrl_next = wd_reg;
                ctrl_next.spare = 1'b0;
            end
            if (awa_reg > AST_RXD_OFS || awa_reg[1:0] != 2'h0) begin
                br_next = AST_RESP_ERR;
            end
        end
        rv_next = doRd || (rv_reg && !rready);
        rd_next = rd_reg;
        rr_next = rr_reg;
        if (doRd) begin
            rr_next = AST_RESP_OK;
            case (araddr)
                AST_MODE_OFS: rd_next = {25'h0, mode_reg};
                AST_RATE_OFS: rd_next = {24'h0, rate_reg};
                AST_CTRL_OFS: rd_next = {24'h0, ctrl_reg};
                AST_TXD_OFS: rd_next = {24'h0, txBuf_reg};
                AST_STAT_OFS: rd_next = {24'h0, stat_reg};
                AST_RXD_OFS: rd_next = {24'h0, rxBuf_reg};
                default: begin
                    rd_next = 32'h0;
                    rr_next = AST_RESP_ERR;
                end
            endcase
        end
    end
    assign awready = !awHave_reg;
    assign wready = !wHave_reg;
    assign bvalid = bv_reg;
    assign bresp = br_reg;
    assign arready = !rv_reg;
    assign rvalid = rv_reg;
    assign rdata = rd_reg;
    assign rresp = rr_reg;
    // ----------------------------------------------------------------
    // clock generation
    // ----------------------------------------------------------------
    // bit rate = mclk / (prescale * (rate+1) * 2 * 16)
    logic [5:0] pre_reg, pre_next, preMax;
    logic [7:0] brg_reg, brg_next;
    logic half_reg, half_next, sck1_reg, sck2_reg, sck3_reg;
    logic preTick, halfTick, tick16;
    always_comb begin
        case (mode_reg.prescale)
            2'h0: preMax = 6'h00;
            2'h1: preMax = 6'h03;
            2'h2: preMax = 6'h0F;
            default: preMax = 6'h3F;
        endcase
        preTick = pre_reg >= preMax;
        pre_next = preTick ? 6'h00 : pre_reg + 6'h01;
        halfTick = preTick && brg_reg >= rate_reg;
        brg_next = brg_reg;
        if (preTick) brg_next = halfTick ? 8'h00 : brg_reg + 8'h01;
        half_next = halfTick ? !half_reg : half_reg;
        // external clock skips the generator entirely
        tick16 = ctrl_reg.extClk ? (sck2_reg && !sck3_reg)
                                 : (halfTick && half_reg);
    end
    assign sckOut = half_reg;
    assign sckOe = ctrl_reg.clkOut && !ctrl_reg.extClk;
    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    ast_state_t txSt_reg, txSt_next;
    logic [3:0] txCnt_reg, txCnt_next;
    logic [2:0] txBit_reg, txBit_next, lastBit;
    logic [7:0] txSh_reg, txSh_next, txRev;
    logic txPar_reg, txPar_next, txd_reg, txd_next, txEnd, txLoad;
    always_comb begin
        lastBit = mode_reg.len7 ? 3'h6 : 3'h7;
        for (int i = 0; i < 8; i++) txRev[i] = txBuf_reg[7 - i];
        txSt_next = txSt_reg;
        txCnt_next = tick16 ? txCnt_reg + 4'h1 : txCnt_reg;
        txBit_next = txBit_reg;
        txSh_next = txSh_reg;
        txPar_next = txPar_reg;
        txEnd = tick16 && txCnt_reg == AST_OVS_LAST;
        txLoad = 1'b0;
        case (txSt_reg)
            AST_IDLE: begin
                txCnt_next = 4'h0;
                txLoad = ctrl_reg.txEn && !stat_reg[AST_ST_TXE];
            end
            AST_START: if (txEnd) txSt_next = AST_DATA;
            AST_DATA: if (txEnd) begin
                txSh_next = {1'b0, txSh_reg[7:1]};
                txBit_next = txBit_reg + 3'h1;
                if (txBit_reg == lastBit) begin
                    txBit_next = 3'h0;
                    txSt_next = mode_reg.parEn ? AST_PAR : AST_STOP;
                end
            end
            AST_PAR: if (txEnd) txSt_next = AST_STOP;
            AST_STOP: if (txEnd) begin
                if (mode_reg.stop2 && txBit_reg == 3'h0) begin
                    txBit_next = 3'h1;
                end else begin
                    txBit_next = 3'h0;
                    txSt_next = AST_IDLE;
                    txLoad = ctrl_reg.txEn && !stat_reg[AST_ST_TXE];
                end
            end
            default: txSt_next = AST_IDLE;
        endcase
        if (txLoad) begin
            txSt_next = AST_START;
            txCnt_next = 4'h0;
            txBit_next = 3'h0;
            txSh_next = txBuf_reg;
            if (mode_reg.msbFirst) begin
                txSh_next = mode_reg.len7 ? {1'b0, txRev[7:1]} : txRev;
            end
            txPar_next = ^(mode_reg.len7 ? {1'b0, txBuf_reg[6:0]} : txBuf_reg)
                         ^ mode_reg.parOdd;
        end
        case (txSt_next)
            AST_START: txd_next = 1'b0;
            AST_DATA: txd_next = txSh_next[0];
            AST_PAR: txd_next = txPar_next;
            default: txd_next = 1'b1;
        endcase
        txBuf_next = txWr ? wd_reg : txBuf_reg;
    end
    assign txdPin = txd_reg;
    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    ast_state_t rxSt_reg, rxSt_next;
    logic [3:0] rxCnt_reg, rxCnt_next;
    logic [2:0] rxBit_reg, rxBit_next;
    logic [7:0] rxSh_reg, rxSh_next, rxWord;
    logic rx1_reg, rxS_reg, rxP_reg, rxAcc_reg, rxAcc_next, rxPe_reg;
    logic rxPe_next, rxSamp, rxMid, rxDone, fer, brk;
    always_comb begin
        rxSt_next = rxSt_reg;
        rxCnt_next = tick16 ? rxCnt_reg + 4'h1 : rxCnt_reg;
        rxBit_next = rxBit_reg;
        rxSh_next = rxSh_reg;
        rxAcc_next = rxAcc_reg;
        rxPe_next = rxPe_reg;
        rxSamp = tick16 && rxCnt_reg == AST_OVS_LAST;
        rxMid = tick16 && rxCnt_reg == AST_OVS_MID;
        rxDone = 1'b0;
        case (rxSt_reg)
            AST_IDLE: begin
                rxCnt_next = 4'h0;
                if (ctrl_reg.rxEn && rxP_reg && !rxS_reg) begin
                    rxSt_next = AST_START;
                    rxBit_next = 3'h0;
                    rxAcc_next = 1'b0;
                    rxPe_next = 1'b0;
                end
            end
            AST_START: if (rxMid) begin
                rxCnt_next = 4'h0; // re-centre on the start bit
                rxSt_next = rxS_reg ? AST_IDLE : AST_DATA;
            end
            AST_DATA: if (rxSamp) begin
                rxAcc_next = rxAcc_reg ^ rxS_reg;
                rxSh_next = mode_reg.msbFirst ? {rxSh_reg[6:0], rxS_reg}
                                              : {rxS_reg, rxSh_reg[7:1]};
                rxBit_next = rxBit_reg + 3'h1;
                if (rxBit_reg == lastBit) begin
                    rxSt_next = mode_reg.parEn ? AST_PAR : AST_STOP;
                end
            end
            AST_PAR: if (rxSamp) begin
                rxPe_next = (rxAcc_reg ^ rxS_reg) != mode_reg.parOdd;
                rxAcc_next = rxS_reg;
                rxSt_next = AST_STOP;
            end
            AST_STOP: if (rxSamp) begin
                rxDone = 1'b1;
                rxSt_next = AST_IDLE;
            end
            default: rxSt_next = AST_IDLE;
        endcase
        if (mode_reg.msbFirst) begin
            rxWord = mode_reg.len7 ? {1'b0, rxSh_reg[6:0]} : rxSh_reg;
        end else begin
            rxWord = mode_reg.len7 ? {1'b0, rxSh_reg[7:1]} : rxSh_reg;
        end
        fer = rxDone && !rxS_reg;
        // break: whole frame low including parity
        brk = fer && rxWord == 8'h00 && !(mode_reg.parEn && rxAcc_reg);
    end
    // ----------------------------------------------------------------
    // status flags: hardware set wins over software clear
    // ----------------------------------------------------------------
    logic rxStore;
    always_comb begin
        rxStore = rxDone && (!stat_reg[AST_ST_RXF] || rxRd);
        stat_next = stat_reg;
        if (stWr) stat_next = stat_reg & ~{2'h0, wd_reg[5:3], 1'b0, 1'b0,
                                           wd_reg[0]};
        if (txWr) begin
            stat_next[AST_ST_TXE] = 1'b0;
            stat_next[AST_ST_TXD] = 1'b0;
        end
        if (rxRd) stat_next[AST_ST_RXF] = 1'b0;
        if (txLoad) stat_next[AST_ST_TXE] = 1'b1;
        if (txEnd && txSt_reg == AST_STOP && txSt_next == AST_IDLE) begin
            stat_next[AST_ST_TXD] = 1'b1;
        end
        if (rxDone && !rxStore) stat_next[AST_ST_OVR] = 1'b1;
        if (rxStore) stat_next[AST_ST_RXF] = 1'b1;
        if (fer) stat_next[AST_ST_FER] = 1'b1;
        if (rxDone && rxPe_reg) stat_next[AST_ST_PER] = 1'b1;
        if (brk) stat_next[AST_ST_BRK] = 1'b1;
        rxBuf_next = rxStore ? rxWord : rxBuf_reg;
    end
    // request lines double as transfer triggers
    assign txEmptyIrq = ctrl_reg.txIe && stat_reg[AST_ST_TXE];
    assign rxFullIrq = ctrl_reg.rxIe && stat_reg[AST_ST_RXF];
    assign rxErrIrq = ctrl_reg.rxIe && |stat_reg[AST_ST_OVR:AST_ST_PER];
    assign txEndIrq = ctrl_reg.endIe && stat_reg[AST_ST_TXD];
    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_reg <= '0;
            ctrl_reg <= '0;
            rate_reg <= AST_RATE_RST;
            txBuf_reg <= 8'h00;
            rxBuf_reg <= 8'h00;
            stat_reg <= AST_STAT_RST;
            awa_reg <= 8'h00;
            wd_reg <= 8'h00;
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            ws_reg <= 1'b0;
            bv_reg <= 1'b0;
            rv_reg <= 1'b0;
            br_reg <= AST_RESP_OK;
            rr_reg <= AST_RESP_OK;
            rd_reg <= 32'h0;
            pre_reg <= 6'h00;
            brg_reg <= 8'h00;
            half_reg <= 1'b0;
            sck1_reg <= 1'b0;
            sck2_reg <= 1'b0;
            sck3_reg <= 1'b0;
            txSt_reg <= AST_IDLE;
            txCnt_reg <= 4'h0;
            txBit_reg <= 3'h0;
            txSh_reg <= 8'h00;
            txPar_reg <= 1'b0;
            txd_reg <= 1'b1;
            rxSt_reg <= AST_IDLE;
            rxCnt_reg <= 4'h0;
            rxBit_reg <= 3'h0;
            rxSh_reg <= 8'h00;
            rx1_reg <= 1'b1;
            rxS_reg <= 1'b1;
            rxP_reg <= 1'b1;
            rxAcc_reg <= 1'b0;
            rxPe_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            ctrl_reg <= ctrl_next;
            rate_reg <= rate_next;
            txBuf_reg <= txBuf_next;
            rxBuf_reg <= rxBuf_next;
            stat_reg <= stat_next;
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            awHave_reg <= awHave_next;
            wHave_reg <= wHave_next;
            ws_reg <= ws_next;
            bv_reg <= bv_next;
            rv_reg <= rv_next;
            br_reg <= br_next;
            rr_reg <= rr_next;
            rd_reg <= rd_next;
            pre_reg <= pre_next;
            brg_reg <= brg_next;
            half_reg <= half_next;
            sck1_reg <= sckIn;
            sck2_reg <= sck1_reg;
            sck3_reg <= sck2_reg;
            txSt_reg <= txSt_next;
            txCnt_reg <= txCnt_next;
            txBit_reg <= txBit_next;
            txSh_reg <= txSh_next;
            txPar_reg <= txPar_next;
            txd_reg <= txd_next;
            rxSt_reg <= rxSt_next;
            rxCnt_reg <= rxCnt_next;
            rxBit_reg <= rxBit_next;
            rxSh_reg <= rxSh_next;
            rx1_reg <= rxdPin;
            rxS_reg <= rx1_reg;
            rxP_reg <= rxS_reg;
            rxAcc_reg <= rxAcc_next;
            rxPe_reg <= rxPe_next;
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_tx_idle_high: assert property (txSt_reg == AST_IDLE |-> txdPin)
        else $error("tx line low while idle");
    a_tx_start_low: assert property (
        txSt_reg == AST_START |-> !txdPin)
        else $error("start bit not low");
    a_rx_start_edge: assert property (
        rxSt_reg == AST_IDLE && ctrl_reg.rxEn && rxP_reg && !rxS_reg
        |=> rxSt_reg == AST_START)
        else $error("start edge missed");
    a_rx_false_start: assert property (
        rxSt_reg == AST_START && rxMid && rxS_reg |=> rxSt_reg == AST_IDLE)
        else $error("false start not rejected");
    a_reset_flags: assert property (
        $past(reset) |-> stat_reg[AST_ST_TXE] && stat_reg[AST_ST_TXD])
        else $error("reset flags wrong");
    a_tx_buf_load: assert property (
        txSt_reg == AST_IDLE && ctrl_reg.txEn && !stat_reg[AST_ST_TXE]
        |=> stat_reg[AST_ST_TXE] && txSt_reg == AST_START ##1 !txdPin)
        else $error("holding buffer not loaded");
    a_fer_set: assert property (
        rxSt_reg == AST_STOP && rxSamp && !rxS_reg
        |=> stat_reg[AST_ST_FER] && (rxErrIrq == ctrl_reg.rxIe))
        else $error("framing error not flagged");
    a_ovr_keep: assert property (
        rxDone && stat_reg[AST_ST_RXF] && !rxRd
        |=> stat_reg[AST_ST_OVR] && $stable(rxBuf_reg))
        else $error("overrun mishandled");
    a_rx_gate: assert property (
        !ctrl_reg.rxIe |-> !rxFullIrq && !rxErrIrq)
        else $error("rx requests not gated");
    c_rx_char: cover property (rxStore ##1 rxFullIrq);
    c_tx_done: cover property (txSt_reg == AST_STOP ##1 txEndIrq);
    c_overrun: cover property (rxDone && !rxStore);
    c_break: cover property (brk);
endmodule : ast_async_serial_unit
`default_nettype wire

// file: ast_remote_end.sv
/*
 behavioural model of the remote serial transceiver on the line side.
 assumes 32 mclk cycles per bit: prescale /1 and rate register zero.
*/
`timescale 1ns/10ps
`default_nettype none
module ast_remote_end (
    input wire logic mclk,
    input wire logic lineIn,
    output logic lineOut
);
    localparam int BIT = 32;
    // ----------------------------------------------------------------
    // line driver and line monitor
    // ----------------------------------------------------------------
    initial lineOut = 1'b1; // mark while idle
    task automatic sendChar(input logic [7:0] d, input logic stopBit);
        @(posedge mclk) lineOut <= 1'b0; // start bit
        repeat (BIT) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            lineOut <= d[i]; // lsb first
            repeat (BIT) @(posedge mclk);
        end
        lineOut <= stopBit; // low only to force a framing fault
        repeat (BIT) @(posedge mclk);
        lineOut <= 1'b1;
        repeat (BIT) @(posedge mclk);
    endtask : sendChar
    task automatic getChar(output logic [7:0] d, output logic stopBit);
        @(negedge lineIn);
        repeat (BIT / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge mclk);
            d[i] = lineIn;
        end
        repeat (BIT) @(posedge mclk);
        stopBit = lineIn;
    endtask : getChar
endmodule : ast_remote_end
`default_nettype wire

// file: ast_async_serial_unit_tb_top.sv
/*
 self-checking bench: register tasks over AXI4-Lite plus line traffic.
 assumes the remote model answers at 32 mclk cycles per bit.
*/
`timescale 1ns/10ps
`default_nettype none
module ast_async_serial_unit_tb_top;
    import ast_pkg::*;
    logic mclk, reset, awvalid, wvalid, bready, arvalid, rready, rxdPin;
    logic awready, wready, bvalid, arready, rvalid, txdPin, sckOut, sckOe;
    logic txEmptyIrq, rxFullIrq, rxErrIrq, txEndIrq, sckIn, s;
    logic [7:0] awaddr, araddr, c;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int miscompares, compares;
    ast_async_serial_unit dut_u (.mclk, .reset, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rxdPin,
        .txdPin, .sckIn, .sckOut, .sckOe, .txEmptyIrq, .rxFullIrq,
        .rxErrIrq, .txEndIrq);
    ast_remote_end partner_u (.mclk, .lineIn(txdPin), .lineOut(rxdPin));
    // ----------------------------------------------------------------
    // bus tasks and checking
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, exp, input string what);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic axiWr(input logic [7:0] a, v, output logic [1:0] rs);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            // look mid-cycle: inputs only move at the rising edge
            @(negedge mclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            rs = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
        // let an edge pass so the next call never re-raises ready at once
        @(posedge mclk);
    endtask : axiWr
    task automatic axiRd(input logic [7:0] a, output logic [31:0] v);
        logic t, tv;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge mclk);
            t = arvalid & arready;
            tv = rvalid;
            v = rdata;
            r = rresp;
            @(posedge mclk);
            if (t) arvalid <= 1'b0;
        end while (!tv);
        rready <= 1'b0;
        @(posedge mclk);
    endtask : axiRd
    task automatic conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    // ----------------------------------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // free-running 16x clock, used only while extClk is set
    always @(posedge mclk) sckIn <= reset ? 1'b0 : !sckIn;
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        conclude();
    end
    initial begin
        {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        axiRd(AST_STAT_OFS, d);
        check(d, 32'h84, "status");
        check(txdPin, 1'b1, "idle");
        axiWr(AST_RATE_OFS, 8'h00, r);
        axiWr(AST_CTRL_OFS, 8'hF4, r);
        check(txEmptyIrq, 1'b1, "txe irq");
        // both directions at once: neither may wait on the other
        fork
            axiWr(AST_TXD_OFS, 8'hA5, r);
            partner_u.sendChar(8'h3C, 1'b1);
            partner_u.getChar(c, s);
        join
        check({s, c}, 9'h1A5, "tx char");
        check(rxFullIrq, 1'b1, "rxf irq");
        axiRd(AST_RXD_OFS, d);
        check(d, 32'h3C, "rx char");
        repeat (40) @(posedge mclk);
        check(txEndIrq, 1'b1, "tx end");
        axiWr(AST_MODE_OFS, 8'h04, r);
        fork
            axiWr(AST_TXD_OFS, 8'h01, r);
            partner_u.getChar(c, s);
        join
        check(c, 8'h80, "msb first");
        // seven bits plus even parity; the incoming parity bit is wrong
        axiWr(AST_MODE_OFS, 8'h60, r);
        check(r, AST_RESP_OK, "write resp");
        fork
            axiWr(AST_TXD_OFS, 8'h01, r);
            partner_u.getChar(c, s);
            partner_u.sendChar(8'h01, 1'b1);
        join
        check({s, c}, 9'h181, "parity tx");
        axiRd(AST_STAT_OFS, d);
        check(d[AST_ST_PER], 1'b1, "parity err");
        axiRd(AST_RXD_OFS, d);
        check(d, 32'h01, "seven bit rx");
        axiWr(AST_STAT_OFS, 8'h08, r);
        check(rxErrIrq, 1'b0, "err clear");
        axiWr(AST_MODE_OFS, 8'h00, r);
        partner_u.sendChar(8'h00, 1'b0);
        check(rxErrIrq, 1'b1, "err irq");
        axiRd(AST_STAT_OFS, d);
        check({d[AST_ST_FER], d[AST_ST_BRK]}, 2'h3, "brk");
        axiWr(AST_STAT_OFS, 8'h31, r);
        axiRd(AST_RXD_OFS, d);
        partner_u.sendChar(8'h11, 1'b1);
        partner_u.sendChar(8'h22, 1'b1);
        axiRd(AST_STAT_OFS, d);
        check(d[AST_ST_OVR], 1'b1, "overrun");
        // slow internal rate, so only the external clock fits the bit time
        axiWr(AST_RATE_OFS, 8'h03, r);
        axiWr(AST_CTRL_OFS, 8'hF6, r);
        fork
            axiWr(AST_TXD_OFS, 8'h5A, r);
            partner_u.getChar(c, s);
        join
        check({s, c}, 9'h15A, "ext clock");
        axiWr(AST_RATE_OFS, 8'h00, r);
        axiWr(AST_CTRL_OFS, 8'hB5, r);
        check({rxFullIrq, rxErrIrq}, 2'h0, "rx gate");
        check(sckOe, 1'b1, "sck drive");
        @(negedge mclk) s = sckOut;
        @(negedge mclk) check(sckOut, !s, "sck toggle");
        @(posedge mclk);
        axiRd(AST_RXD_OFS, d);
        check(d, 32'h11, "kept char");
        axiRd(8'h20, d);
        check(r, AST_RESP_ERR, "unmapped");
        axiWr(8'h20, 8'h00, r);
        check(r, AST_RESP_ERR, "unmapped wr");
        conclude();
    end
endmodule : ast_async_serial_unit_tb_top
`default_nettype wire
